// ==== pll_clock_setup_defs.vh ====
// register map, field layout and reset values of the clock setup block
`ifndef PLL_CLOCK_SETUP_DEFS_VH
`define PLL_CLOCK_SETUP_DEFS_VH

// register byte offsets
`define OFS_STATUS        8'h00
`define OFS_IRQ_MASK      8'h04
`define OFS_PLL_A_CONFIG  8'h08
`define OFS_PLL_B_CONFIG  8'h0C
`define OFS_MASTER_CLOCK  8'h10

// pll a configuration word
`define PLLA_DIV_LSB      0
`define PLLA_DIV_MSB      7
`define PLLA_CNT_LSB      8
`define PLLA_CNT_MSB      13
`define PLLA_MUL_LSB      16
`define PLLA_MUL_MSB      26
`define PLLA_SRC_BIT      29

// pll b configuration word
`define PLLB_DIV_LSB      0
`define PLLB_DIV_MSB      7
`define PLLB_CNT_LSB      8
`define PLLB_CNT_MSB      13
`define PLLB_RNG_LSB      14
`define PLLB_RNG_MSB      15
`define PLLB_MUL_LSB      16
`define PLLB_MUL_MSB      26
`define PLLB_USB_LSB      28
`define PLLB_USB_MSB      29

// master clock word
`define MCK_CSS_LSB       0
`define MCK_CSS_MSB       1
`define MCK_CSS_SLOW      2'h0

// status and mask layout
`define ST_LOCK_A_EV      0
`define ST_LOCK_B_EV      1
`define ST_LOCK_A_LVL     16
`define ST_LOCK_B_LVL     17
`define IRQ_BITS_MASK     32'h00000003

// usb divider codes
`define USB_DIV_1         2'h0
`define USB_DIV_2         2'h1
`define USB_DIV_4         2'h2

// reset values
`define PLL_CONFIG_RESET  32'h00000000
`define MCK_RESET         32'h00000000

`endif

// ==== pll_lock_timer.v ====
// lock counter for one pll, counting slow clock ticks after a config write
`timescale 1ns/1ps
`default_nettype none
module pll_lock_timer #(
  parameter CW = 6
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          load,
  input  wire [CW-1:0] count,
  input  wire          slow_tick,
  output reg           locked,
  output reg           lock_event
);

  reg [CW-1:0] cnt_r;
  reg          busy_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r      <= {CW{1'b0}};
      busy_r     <= 1'b0;
      locked     <= 1'b0;
      lock_event <= 1'b0;
    end else begin
      lock_event <= 1'b0;
      if (load) begin
        // every write restarts from the new count
        cnt_r  <= count;
        busy_r <= 1'b1;
        locked <= 1'b0;
      end else if (busy_r && cnt_r == {CW{1'b0}}) begin
        busy_r     <= 1'b0;
        locked     <= 1'b1;
        lock_event <= 1'b1;
      end else if (busy_r && slow_tick) begin
        cnt_r <= cnt_r - {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule
`default_nettype wire

// ==== pulse_divider.v ====
// divides a stream of one-cycle pulses by a programmable factor
`timescale 1ns/1ps
`default_nettype none
module pulse_divider #(
  parameter DW = 8
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          in_pulse,
  input  wire [DW-1:0] factor,
  output reg           out_pulse
);

  reg [DW-1:0] cnt_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r     <= {DW{1'b0}};
      out_pulse <= 1'b0;
    end else begin
      out_pulse <= 1'b0;
      if (factor == {DW{1'b0}}) begin
        // zero factor keeps the divider off
        cnt_r <= {DW{1'b0}};
      end else if (in_pulse) begin
        if (cnt_r >= factor - {{(DW-1){1'b0}}, 1'b1}) begin
          cnt_r     <= {DW{1'b0}};
          out_pulse <= 1'b1;
        end else begin
          cnt_r <= cnt_r + {{(DW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule
`default_nettype wire

// ==== pll_clock_setup.v ====
// pll configuration, lock timing, usb divider and master clock select
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "pll_clock_setup_defs.vh"
`default_nettype none
module pll_clock_setup #(
  parameter CW = 6,
  parameter DW = 8,
  parameter MW = 11
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [7:0]    paddr,
  input  wire [31:0]   pwdata,
  output wire          pready,
  output wire          pslverr,
  output reg  [31:0]   prdata,
  input  wire          slow_clk,
  input  wire          main_clk,
  input  wire          pll_b_clk,
  output wire          irq,
  output wire          pll_a_locked,
  output wire          pll_b_locked,
  output reg           pll_a_source_sel,
  output reg  [MW-1:0] pll_a_multiplier,
  output reg  [DW-1:0] pll_a_divider,
  output reg           pll_a_on,
  output reg  [MW:0]   pll_a_factor,
  output reg  [MW-1:0] pll_b_multiplier,
  output reg  [DW-1:0] pll_b_divider,
  output reg  [1:0]    pll_b_range_sel,
  output reg           pll_b_on,
  output reg  [MW:0]   pll_b_factor,
  output reg  [1:0]    usb_clock_divider,
  output reg  [1:0]    master_clock_source_sel,
  output wire          pll_a_ref_pulse,
  output wire          pll_b_ref_pulse,
  output wire          usb_clk_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers and edge detectors

  reg [1:0] slow_sync_r;
  reg       slow_prev_r;
  reg [1:0] main_sync_r;
  reg       main_prev_r;
  reg [1:0] pllb_sync_r;
  reg       pllb_prev_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_sync_r <= 2'h0;
      slow_prev_r <= 1'b0;
      main_sync_r <= 2'h0;
      main_prev_r <= 1'b0;
      pllb_sync_r <= 2'h0;
      pllb_prev_r <= 1'b0;
    end else begin
      slow_sync_r <= {slow_sync_r[0], slow_clk};
      slow_prev_r <= slow_sync_r[1];
      main_sync_r <= {main_sync_r[0], main_clk};
      main_prev_r <= main_sync_r[1];
      pllb_sync_r <= {pllb_sync_r[0], pll_b_clk};
      pllb_prev_r <= pllb_sync_r[1];
    end
  end

  // only the second stage is looked at
  wire slow_tick = slow_sync_r[1] & ~slow_prev_r;
  wire main_rise = main_sync_r[1] & ~main_prev_r;
  wire pllb_rise = pllb_sync_r[1] & ~pllb_prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, error on unmapped offsets

  wire setup_ph  = psel & ~penable;
  wire access_ph = psel & penable;
  wire wr_en     = access_ph & pwrite;

  reg  addr_ok;
  always @* begin
    case (paddr)
      `OFS_STATUS,
      `OFS_IRQ_MASK,
      `OFS_PLL_A_CONFIG,
      `OFS_PLL_B_CONFIG,
      `OFS_MASTER_CLOCK: addr_ok = 1'b1;
      default:           addr_ok = 1'b0;
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = access_ph & ~addr_ok;

  wire wr_stat = wr_en & (paddr == `OFS_STATUS);
  wire wr_mask = wr_en & (paddr == `OFS_IRQ_MASK);
  wire wr_plla = wr_en & (paddr == `OFS_PLL_A_CONFIG);
  wire wr_pllb = wr_en & (paddr == `OFS_PLL_B_CONFIG);
  wire wr_mck  = wr_en & (paddr == `OFS_MASTER_CLOCK);

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  reg [CW-1:0] pll_a_lock_count;
  reg [CW-1:0] pll_b_lock_count;
  reg [31:0]   mask_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_a_source_sel        <= 1'b0;
      pll_a_multiplier        <= {MW{1'b0}};
      pll_a_divider           <= {DW{1'b0}};
      pll_a_lock_count        <= {CW{1'b0}};
      pll_b_multiplier        <= {MW{1'b0}};
      pll_b_divider           <= {DW{1'b0}};
      pll_b_lock_count        <= {CW{1'b0}};
      pll_b_range_sel         <= 2'h0;
      usb_clock_divider       <= 2'h0;
      master_clock_source_sel <= `MCK_CSS_SLOW;
      mask_r                  <= 32'h00000000;
    end else begin
      if (wr_plla) begin
        // all fields in one write
        pll_a_source_sel <= pwdata[`PLLA_SRC_BIT];
        pll_a_multiplier <= pwdata[`PLLA_MUL_MSB:`PLLA_MUL_LSB];
        pll_a_divider    <= pwdata[`PLLA_DIV_MSB:`PLLA_DIV_LSB];
        pll_a_lock_count <= pwdata[`PLLA_CNT_MSB:`PLLA_CNT_LSB];
      end
      if (wr_pllb) begin
        pll_b_multiplier  <= pwdata[`PLLB_MUL_MSB:`PLLB_MUL_LSB];
        pll_b_divider     <= pwdata[`PLLB_DIV_MSB:`PLLB_DIV_LSB];
        pll_b_lock_count  <= pwdata[`PLLB_CNT_MSB:`PLLB_CNT_LSB];
        pll_b_range_sel   <= pwdata[`PLLB_RNG_MSB:`PLLB_RNG_LSB];
        usb_clock_divider <= pwdata[`PLLB_USB_MSB:`PLLB_USB_LSB];
      end
      if (wr_mck) begin
        master_clock_source_sel <= pwdata[`MCK_CSS_MSB:`MCK_CSS_LSB];
      end
      if (wr_mask) begin
        mask_r <= pwdata & `IRQ_BITS_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pll enables and multiplication factors

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_a_on     <= 1'b0;
      pll_a_factor <= {(MW+1){1'b0}};
      pll_b_on     <= 1'b0;
      pll_b_factor <= {(MW+1){1'b0}};
    end else begin
      pll_a_on     <= (pll_a_multiplier != {MW{1'b0}});
      pll_a_factor <= {1'b0, pll_a_multiplier} + {{MW{1'b0}}, 1'b1};
      // zero multiplier keeps pll b off
      pll_b_on     <= (pll_b_multiplier != {MW{1'b0}});
      pll_b_factor <= (pll_b_multiplier == {MW{1'b0}}) ? {(MW+1){1'b0}} :
                      {1'b0, pll_b_multiplier} + {{MW{1'b0}}, 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lock counters: a write always restarts, which covers field changes

  wire lock_a_ev;
  wire lock_b_ev;

  pll_lock_timer #(.CW(CW)) lock_a (
    .pclk       (pclk),
    .presetn    (presetn),
    .load       (wr_plla),
    .count      (pwdata[`PLLA_CNT_MSB:`PLLA_CNT_LSB]),
    .slow_tick  (slow_tick),
    .locked     (pll_a_locked),
    .lock_event (lock_a_ev)
  );

  pll_lock_timer #(.CW(CW)) lock_b (
    .pclk       (pclk),
    .presetn    (presetn),
    .load       (wr_pllb),
    .count      (pwdata[`PLLB_CNT_MSB:`PLLB_CNT_LSB]),
    .slow_tick  (slow_tick),
    .locked     (pll_b_locked),
    .lock_event (lock_b_ev)
  );

  ////////////////////////////////////////////////////////////////////////////
  // reference dividers and usb divider

  pulse_divider #(.DW(DW)) div_a (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_pulse  (main_rise),
    .factor    (pll_a_divider),
    .out_pulse (pll_a_ref_pulse)
  );

  // pll b reference is the main clock through divider b
  pulse_divider #(.DW(DW)) div_b (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_pulse  (main_rise),
    .factor    (pll_b_divider),
    .out_pulse (pll_b_ref_pulse)
  );

  reg [2:0] usb_factor;
  always @* begin
    case (usb_clock_divider)
      `USB_DIV_1: usb_factor = 3'h1;
      `USB_DIV_2: usb_factor = 3'h2;
      `USB_DIV_4: usb_factor = 3'h4;
      default:    usb_factor = 3'h4;   // reserved code treated as four
    endcase
  end

  pulse_divider #(.DW(3)) div_usb (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_pulse  (pllb_rise),
    .factor    (usb_factor),
    .out_pulse (usb_clk_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sticky lock events, write one to clear, set wins over clear

  reg [1:0] ev_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_r <= 2'h0;
    end else begin
      ev_r[`ST_LOCK_A_EV] <= lock_a_ev |
        (ev_r[`ST_LOCK_A_EV] & ~(wr_stat & pwdata[`ST_LOCK_A_EV]));
      ev_r[`ST_LOCK_B_EV] <= lock_b_ev |
        (ev_r[`ST_LOCK_B_EV] & ~(wr_stat & pwdata[`ST_LOCK_B_EV]));
    end
  end

  assign irq = |(ev_r & mask_r[1:0]);

  ////////////////////////////////////////////////////////////////////////////
  // read data, registered in the setup phase

  reg [31:0] status_word;
  reg [31:0] rd_mux;
  always @* begin
    status_word = 32'h00000000;
    status_word[`ST_LOCK_A_EV]  = ev_r[`ST_LOCK_A_EV];
    status_word[`ST_LOCK_B_EV]  = ev_r[`ST_LOCK_B_EV];
    status_word[`ST_LOCK_A_LVL] = pll_a_locked;
    status_word[`ST_LOCK_B_LVL] = pll_b_locked;
    rd_mux = 32'h00000000;
    case (paddr)
      `OFS_STATUS:   rd_mux = status_word;
      `OFS_IRQ_MASK: rd_mux = mask_r;
      `OFS_PLL_A_CONFIG: begin
        rd_mux[`PLLA_SRC_BIT] = pll_a_source_sel;
        rd_mux[`PLLA_MUL_MSB:`PLLA_MUL_LSB] = pll_a_multiplier;
        rd_mux[`PLLA_CNT_MSB:`PLLA_CNT_LSB] = pll_a_lock_count;
        rd_mux[`PLLA_DIV_MSB:`PLLA_DIV_LSB] = pll_a_divider;
      end
      `OFS_PLL_B_CONFIG: begin
        rd_mux[`PLLB_USB_MSB:`PLLB_USB_LSB] = usb_clock_divider;
        rd_mux[`PLLB_MUL_MSB:`PLLB_MUL_LSB] = pll_b_multiplier;
        rd_mux[`PLLB_RNG_MSB:`PLLB_RNG_LSB] = pll_b_range_sel;
        rd_mux[`PLLB_CNT_MSB:`PLLB_CNT_LSB] = pll_b_lock_count;
        rd_mux[`PLLB_DIV_MSB:`PLLB_DIV_LSB] = pll_b_divider;
      end
      `OFS_MASTER_CLOCK:
        rd_mux[`MCK_CSS_MSB:`MCK_CSS_LSB] = master_clock_source_sel;
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_ph && !pwrite) begin
      prdata <= rd_mux;
    end
  end

endmodule
`default_nettype wire

// ==== pll_clock_setup_properties.sv ====
// checker of the clock setup block ports, with its bind
`timescale 1ns/1ps
`default_nettype none
`include "pll_clock_setup_defs.vh"
module pll_clock_setup_props #(
  parameter DW = 8,
  parameter MW = 11
) (
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [7:0]    paddr,
  input wire logic [31:0]   pwdata,
  input wire logic          irq,
  input wire logic          pll_a_locked,
  input wire logic          pll_b_locked,
  input wire logic          pll_a_on,
  input wire logic [MW-1:0] pll_a_multiplier,
  input wire logic [MW:0]   pll_a_factor,
  input wire logic          pll_b_on,
  input wire logic [MW-1:0] pll_b_multiplier,
  input wire logic [MW:0]   pll_b_factor,
  input wire logic [DW-1:0] pll_b_divider,
  input wire logic [1:0]    usb_clock_divider,
  input wire logic [1:0]    master_clock_source_sel,
  input wire logic          pll_b_ref_pulse,
  input wire logic          usb_clk_pulse
);
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire wr_a = psel && penable && pwrite && paddr == `OFS_PLL_A_CONFIG;
  wire wr_b = psel && penable && pwrite && paddr == `OFS_PLL_B_CONFIG;
  wire cnt_a = |pwdata[`PLLA_CNT_MSB:`PLLA_CNT_LSB];
  wire cnt_b = |pwdata[`PLLB_CNT_MSB:`PLLB_CNT_LSB];
  ////////////////////////////////////////////////////////////////////////
  lock_drop_a_a: assert property (wr_a |=> !pll_a_locked)
    else $error("pll a lock stayed up after write");
  lock_drop_b_a: assert property (wr_b |=> !pll_b_locked)
    else $error("pll b lock stayed up after write");
  // a nonzero count needs a synced tick, so two low samples at least
  lock_wait_a_a: assert property (
    wr_a && cnt_a |=> !pll_a_locked [*2])
    else $error("pll a locked too early");
  lock_wait_b_a: assert property (
    wr_b && cnt_b |=> !pll_b_locked [*2])
    else $error("pll b locked too early");
  // a zero multiplier leaves pll a off with a factor of one, so only nonzero
  factor_a_a: assert property (
    $stable(pll_a_multiplier) && pll_a_multiplier != 0 |->
    pll_a_on && pll_a_factor == {1'b0, pll_a_multiplier} + 1'b1)
    else $error("pll a factor wrong");
  factor_b_a: assert property ($stable(pll_b_multiplier) |->
    pll_b_on == (pll_b_multiplier != 0) && pll_b_factor ==
    ((pll_b_multiplier == 0) ? '0 : {1'b0, pll_b_multiplier} + 1'b1))
    else $error("pll b factor wrong");
  div_off_a: assert property (pll_b_divider == 0 &&
    $past(pll_b_divider) == 0 && $past(pll_b_divider, 2) == 0 |->
    !pll_b_ref_pulse)
    else $error("divider b pulsed while off");
  ref_gap_a: assert property (
    pll_b_ref_pulse && pll_b_divider > 1 |=> !pll_b_ref_pulse)
    else $error("divider b pulses too close");
  usb_gap_a: assert property (usb_clk_pulse &&
    usb_clock_divider == `USB_DIV_4 && $stable(usb_clock_divider) |=>
    !usb_clk_pulse [*7])
    else $error("usb divide by four too fast");
  reset_vals_a: assert property ($rose(presetn) |->
    master_clock_source_sel == `MCK_CSS_SLOW && pll_b_divider == 0)
    else $error("reset values wrong");
  cover property ($rose(pll_a_locked));
  cover property ($rose(irq));
  cover property (usb_clk_pulse && usb_clock_divider == `USB_DIV_4);
endmodule
bind pll_clock_setup pll_clock_setup_props #(.DW(DW), .MW(MW))
  pll_clock_setup_props_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .irq,
  .pll_a_locked, .pll_b_locked, .pll_a_on, .pll_a_multiplier,
  .pll_a_factor, .pll_b_on, .pll_b_multiplier, .pll_b_factor,
  .pll_b_divider, .usb_clock_divider, .master_clock_source_sel,
  .pll_b_ref_pulse, .usb_clk_pulse
);
`default_nettype wire

// ==== tb_pll_clock_setup.sv ====
// self-checking bench for the pll clock setup block
`timescale 1ns/1ps
`default_nettype none
`include "pll_clock_setup_defs.vh"
module tb_pll_clock_setup;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0]  ph = 4'h0;
  logic [31:0] q;
  logic        e;
  int          n_errors = 0;
  int          compares = 0;
  int          cyc = 0;
  int          n;
  wire         pready, pslverr, irq, pll_a_locked, pll_b_locked;
  wire         pll_a_source_sel, pll_a_on, pll_b_on;
  wire         pll_a_ref_pulse, pll_b_ref_pulse, usb_clk_pulse;
  wire [31:0]  prdata;
  wire [10:0]  pll_a_multiplier, pll_b_multiplier;
  wire [11:0]  pll_a_factor, pll_b_factor;
  wire [7:0]   pll_a_divider, pll_b_divider;
  wire [1:0]   pll_b_range_sel, master_clock_source_sel, usb_clock_divider;
  // slow clock 16 cycles, main and pll b clocks 4 cycles
  wire         slow_clk = ph[3];
  wire         main_clk = ph[1];
  wire         pll_b_clk = ph[1];

  pll_clock_setup pll_clock_setup_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .prdata, .slow_clk, .main_clk, .pll_b_clk, .irq,
    .pll_a_locked, .pll_b_locked, .pll_a_source_sel, .pll_a_multiplier,
    .pll_a_divider, .pll_a_on, .pll_a_factor, .pll_b_multiplier,
    .pll_b_divider, .pll_b_range_sel, .pll_b_on, .pll_b_factor,
    .usb_clock_divider, .master_clock_source_sel,
    .pll_a_ref_pulse, .pll_b_ref_pulse, .usb_clk_pulse
  );

  initial begin
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    ph <= ph + 4'h1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      stop_test;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task stop_test;
    if (n_errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // outputs are looked at once the registered copies have settled
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    @(posedge pclk);
    @(negedge pclk);
  endtask
  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h00000000);
  endtask
  // writes start just after a slow fall, so no tick is in flight
  task sync_fall;
    do @(posedge pclk); while (ph !== 4'hF);
  endtask
  task ticks(input logic b, output int t);
    t = 0;
    @(posedge pclk);
    while ((b ? pll_b_locked : pll_a_locked) !== 1'b1) begin
      @(posedge pclk);
      if (ph == 4'h7)
        t++;
    end
  endtask
  // u selects: 0 pll b reference, 1 usb clock, 2 pll a reference
  function automatic logic pick(input logic [1:0] u);
    case (u)
      2'h0:    return pll_b_ref_pulse;
      2'h1:    return usb_clk_pulse;
      default: return pll_a_ref_pulse;
    endcase
  endfunction
  task gap(input logic [1:0] u, output int g);
    g = 0;
    do @(posedge pclk); while (pick(u) !== 1'b1);
    do begin
      @(posedge pclk);
      g++;
    end while (pick(u) !== 1'b1);
  endtask
  task wait_irq(input logic v);
    int k;
    k = 0;
    while (irq !== v && k < 8) begin
      @(negedge pclk);
      k++;
    end
    chk(32'(irq), 32'(v));
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_reset;
    for (int a = 0; a <= 16; a += 4) begin
      rd(8'(a));
      chk(q, 32'h00000000);
    end
    chk(32'({pll_b_divider, master_clock_source_sel}), 32'h0);
    rd(8'h14);
    chk({q[30:0], e}, 32'h00000001);
  endtask
  task t_lock_a;
    sync_fall;
    wr(`OFS_PLL_A_CONFIG, 32'h20030605);
    chk(32'({pll_a_source_sel, pll_a_multiplier, pll_a_divider}),
        32'({1'b1, 11'h003, 8'h05}));
    chk(32'({pll_a_on, pll_a_factor}), 32'h00001004);
    ticks(1'b0, n);
    chk(32'(n), 32'h6);
    rd(`OFS_STATUS);
    chk(q, 32'h00010001);
    chk(32'(irq), 32'h0);
  endtask
  task t_relock;
    repeat (2) begin
      sync_fall;
      wr(`OFS_PLL_A_CONFIG, 32'h20030202);
      chk(32'(pll_a_locked), 32'h0);
      ticks(1'b0, n);
      chk(32'(n), 32'h2);
    end
    gap(2'h2, n);
    chk(32'(n), 32'd8);
  endtask
  task t_lock_b;
    wr(`OFS_IRQ_MASK, 32'h00000002);
    wait_irq(1'b0);
    sync_fall;
    wr(`OFS_PLL_B_CONFIG, 32'h00040805);
    chk(32'({pll_b_on, pll_b_factor}), 32'h00001005);
    ticks(1'b1, n);
    chk(32'(n), 32'h8);
    wait_irq(1'b1);
    rd(`OFS_STATUS);
    chk(q, 32'h00030003);
    wr(`OFS_STATUS, 32'h00000002);
    wait_irq(1'b0);
    rd(`OFS_STATUS);
    chk(q, 32'h00030001);
    gap(2'h0, n);
    chk(32'(n), 32'd20);
    wr(`OFS_PLL_B_CONFIG, 32'h00050805);
    chk(32'(pll_b_locked), 32'h0);
  endtask
  task t_mul;
    wr(`OFS_PLL_B_CONFIG, 32'h07FFC0FF);
    chk(32'({pll_b_on, pll_b_factor}), 32'h00001800);
    chk(32'(pll_b_multiplier), 32'h000007FF);
    chk(32'({pll_b_range_sel, pll_b_divider}), 32'h3FF);
    rd(`OFS_PLL_B_CONFIG);
    chk(q, 32'h07FFC0FF);
    wr(`OFS_PLL_B_CONFIG, 32'h0000C000);
    chk(32'({pll_b_on, pll_b_factor}), 32'h00000000);
    n = 0;
    repeat (64) begin
      @(negedge pclk);
      if (pll_b_ref_pulse !== 1'b0)
        n++;
    end
    chk(32'(n), 32'h0);
  endtask
  task t_usb;
    // code 3 is reserved and behaves as divide by four
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_PLL_B_CONFIG, 32'h00040805 | (32'(i) << `PLLB_USB_LSB));
      chk(32'(usb_clock_divider), 32'(i));
      gap(2'h1, n);
      chk(32'(n), 32'(i == 3 ? 16 : 4 << i));
    end
  endtask
  // non-zero settings first, so the reset values really have to be restored
  task t_mck;
    wr(`OFS_MASTER_CLOCK, 32'h00000003);
    chk(32'(master_clock_source_sel), 32'h3);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk(32'({master_clock_source_sel, pll_b_divider}), 32'h0);
    chk(32'({pll_a_locked, pll_b_locked, irq}), 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_lock_a;
    t_relock;
    t_lock_b;
    t_mul;
    t_usb;
    t_mck;
    stop_test;
  end
endmodule
`default_nettype wire
